// *** src/acs_conv_ctrl.sv ***
// Serial conversion control: control word, sampling sequence, result shift-out, power modes
//
// Functional notes
// - Mode bits 11: drop to standby at the last rising clock edge of each conversion.
// - Standby keeps only the reference powered; wake-up is therefore short.
// - Standby is left on the first falling clock edge after chip select falls.
// - Standby wake completes within the same transfer; no dummy transfer is needed.
// - The serial clock alone paces conversion and data shifting.
// - Chip select falling gates the clock in and puts the sampler into track.
// - Second rising edge after chip select falls: hold, sample, start conversion.
// - Conversion runs a further fourteen clock periods after sampling, ending at the sixteenth rising edge.
// - Chip select rising releases the data output.
// - Chip select held low after a transfer starts the next sequence at once.
// - Sampled channel comes from the previous control word; host writes ahead.
// - Control word taken from data input on the first eight rising edges.
// - Control word is rewritten on every transfer that reaches the eighth rising edge; host must send valid bits.
// - A falling first edge shifts out the first leading zero.
// - Later output bits change on falling edges for capture on rising edges.
// - Last result bit leaves on the falling edge after the fifteenth rising edge, valid at sixteenth rising.
// - Mode bits 00: powered while chip select low, shut down while high.
// - Mode bits 01: always fully powered.
// - Mode bits 10: shut down after each conversion, wake on first falling edge.
// - Control word resets to zero; wake from shutdown takes about 5 us.
`timescale 1ns/1ps
module acs_conv_ctrl
    import acs_pkg::*;
(
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             cs_n_i,
    input  wire logic             sclk_i,
    input  wire logic             din_i,
    output logic                  dout_o,
    output logic                  dout_oe_o,
    input  wire logic             result_valid_i,
    input  wire logic [RES_W-1:0] result_data_i,
    output logic                  result_ready_o,
    output logic                  track_hold_o,
    output logic                  conv_start_o,
    output logic                  conv_busy_o,
    output logic                  xfer_done_o,
    output logic                  chan_sel_o,
    output logic [CTRL_W-1:0]     ctrl_word_o,
    output logic                  power_mode_high_bit_o,
    output logic                  power_mode_low_bit_o,
    output logic                  core_power_o,
    output logic                  ref_power_o,
    output logic                  power_ready_o
);
    // ----------------------------------------------------------------
    // Edge detection and derived events
    // ----------------------------------------------------------------
    logic [1:0]        rise;
    logic [1:0]        fall;
    logic              cs_fall;
    logic              sclk_rise;
    logic              sclk_fall;
    logic [CNT_W-1:0]  rise_cnt_reg;
    logic [CTRL_W-1:0] shift_reg;
    logic [CTRL_W-1:0] ctrl_reg;
    logic [WORD_W-1:0] out_word_reg;
    logic              dout_reg;
    logic              dout_oe_reg;
    logic              hold_reg;
    logic              conv_start_reg;
    logic              busy_reg;
    logic              done_reg;
    logic              chan_reg;
    logic              first_fall_reg;
    logic              end_evt;
    logic              load_evt;
    logic              wake_evt;
    logic              sample_evt;
    logic              buf_valid;
    logic [RES_W-1:0]  buf_data;
    acs_pmode_t        mode;
    acs_pwr_t          pwr_reg;
    logic [WAKE_W-1:0] wake_cnt_reg;

    acs_edge u_edge (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .sig_i   ({sclk_i, cs_n_i}),
        .rise_o  (rise),
        .fall_o  (fall)
    );

    // Clock edges only count while chip select is low
    assign cs_fall   = fall[0];
    assign sclk_rise = rise[1] & ~cs_n_i;
    assign sclk_fall = fall[1] & ~cs_n_i;
    assign end_evt   = sclk_rise & (rise_cnt_reg == LAST_CNT);
    assign load_evt  = sclk_rise & (rise_cnt_reg == LOAD_CNT);
    assign wake_evt  = sclk_fall & first_fall_reg;
    assign sample_evt = sclk_rise & (rise_cnt_reg == SAMPLE_CNT);
    assign mode      = acs_mode(ctrl_reg);

    // ----------------------------------------------------------------
    // Result buffer between the converter core and the shifter
    // ----------------------------------------------------------------
    // A late result is kept rather than lost; it goes out on a later transfer
    acs_fifo2 #(
        .DW (RES_W)
    ) u_buf (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (result_valid_i),
        .in_ready_o  (result_ready_o),
        .in_data_i   (result_data_i),
        .out_valid_o (buf_valid),
        .out_ready_i (load_evt),
        .out_data_o  (buf_data)
    );

    // ----------------------------------------------------------------
    // Transfer sequencing
    // ----------------------------------------------------------------
    // Rising edge counter; wraps at the sixteenth edge so a held-low select restarts
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rise_cnt_reg <= '0;
        end else if (cs_fall || cs_n_i) begin
            rise_cnt_reg <= '0;
        end else if (end_evt) begin
            rise_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rise_cnt_reg <= CNT_W'(rise_cnt_reg + 1'b1);
        end
    end

    // Track on select fall or sequence restart, hold on the second rising edge
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            hold_reg       <= 1'b0;
            conv_start_reg <= 1'b0;
            chan_reg       <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            if (cs_fall || end_evt) begin
                hold_reg <= 1'b0;
            end else if (sample_evt) begin
                hold_reg       <= 1'b1;
                conv_start_reg <= 1'b1;
                chan_reg       <= ctrl_reg[BIT_CHAN];
            end
        end
    end

    // Busy from the sampling edge through the sixteenth rising edge
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= end_evt;
            if (cs_n_i || end_evt) begin
                busy_reg <= 1'b0;
            end else if (sample_evt) begin
                busy_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control word capture
    // ----------------------------------------------------------------
    // Always overwritten at the eighth edge; a short frame keeps the old word
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            shift_reg <= CTRL_RESET;
            ctrl_reg  <= CTRL_RESET;
        end else if (sclk_rise && rise_cnt_reg <= CTRL_CNT) begin
            shift_reg <= {shift_reg[CTRL_W-2:0], din_i};
            if (rise_cnt_reg == CTRL_CNT) begin
                ctrl_reg <= {shift_reg[CTRL_W-2:0], din_i};
            end
        end
    end

    // ----------------------------------------------------------------
    // Result shift-out
    // ----------------------------------------------------------------
    // Word loads at the fourth rising edge, just before its first data bit is due
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            out_word_reg <= '0;
        end else if (cs_fall) begin
            out_word_reg <= '0;
        end else if (load_evt) begin
            out_word_reg <= buf_valid ? {LEAD_ZEROS, buf_data} : '0;
        end
    end

    // Bit index follows the rising count, so either clock phase lines up
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dout_reg <= 1'b0;
        end else if (cs_fall) begin
            dout_reg <= 1'b0;
        end else if (sclk_fall) begin
            dout_reg <= out_word_reg[4'(LAST_CNT - rise_cnt_reg)];
        end
    end

    // Output is driven only while selected
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            dout_oe_reg <= 1'b0;
        end else if (cs_n_i) begin
            dout_oe_reg <= 1'b0;
        end else if (cs_fall) begin
            dout_oe_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Power management
    // ----------------------------------------------------------------
    // Marks the first falling clock edge of a frame for the auto modes
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            first_fall_reg <= 1'b0;
        end else if (cs_fall) begin
            first_fall_reg <= 1'b1;
        end else if (sclk_fall || cs_n_i) begin
            first_fall_reg <= 1'b0;
        end
    end

    // Modes in which the select level alone asks for power; shared by off and standby
    function automatic logic level_wake(input acs_pmode_t m, input logic sel_n);
        return (m == PM_CS_CTRL && !sel_n) || (m == PM_NORMAL);
    endfunction

    // Power state; the wake count is reloaded according to what was powered down
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pwr_reg      <= PWR_OFF;
            wake_cnt_reg <= '0;
        end else begin
            case (pwr_reg)
                PWR_OFF: begin
                    if (level_wake(mode, cs_n_i) || (mode inside {PM_AUTO_SHDN, PM_AUTO_STBY} && wake_evt)) begin
                        pwr_reg      <= PWR_WAKE;
                        wake_cnt_reg <= WAKE_W'(WAKE_OFF_CYC - 1);
                    end
                end
                PWR_STBY: begin
                    if (level_wake(mode, cs_n_i) || wake_evt) begin
                        pwr_reg      <= PWR_WAKE;
                        wake_cnt_reg <= WAKE_W'(WAKE_STBY_CYC - 1);
                    end else if (mode == PM_CS_CTRL) begin
                        pwr_reg <= PWR_OFF;
                    end
                end
                PWR_WAKE: begin
                    if (mode == PM_CS_CTRL && cs_n_i) begin
                        pwr_reg <= PWR_OFF;
                    end else if (wake_cnt_reg == '0) begin
                        pwr_reg <= PWR_ON;
                    end else begin
                        wake_cnt_reg <= WAKE_W'(wake_cnt_reg - 1'b1);
                    end
                end
                PWR_ON: begin
                    if (mode == PM_CS_CTRL && cs_n_i) begin
                        pwr_reg <= PWR_OFF;
                    end else if (end_evt && mode == PM_AUTO_SHDN) begin
                        pwr_reg <= PWR_OFF;
                    end else if (end_evt && mode == PM_AUTO_STBY) begin
                        pwr_reg <= PWR_STBY;
                    end
                end
                default: begin
                    pwr_reg <= PWR_OFF;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign dout_o                = dout_reg;
    assign dout_oe_o             = dout_oe_reg;
    assign track_hold_o          = hold_reg;
    assign conv_start_o          = conv_start_reg;
    assign conv_busy_o           = busy_reg;
    assign xfer_done_o           = done_reg;
    assign chan_sel_o            = chan_reg;
    assign ctrl_word_o           = ctrl_reg;
    assign power_mode_high_bit_o = ctrl_reg[BIT_PM1];
    assign power_mode_low_bit_o  = ctrl_reg[BIT_PM0];
    // Standby keeps the reference alive, which is why its wake is short
    assign core_power_o          = (pwr_reg == PWR_WAKE) || (pwr_reg == PWR_ON);
    assign ref_power_o           = (pwr_reg != PWR_OFF);
    assign power_ready_o         = (pwr_reg == PWR_ON);
endmodule

// *** src/acs_pkg.sv ***
// Constants, types and decode helpers for the serial conversion control block
package acs_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_OFF_NS   = 5000;
    localparam int WAKE_STBY_NS  = 1000;
    localparam int WAKE_OFF_CYC  = (WAKE_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_STBY_CYC = (WAKE_STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_W        = 10;

    // ----------------------------------------------------------------
    // Word layout and edge counts
    // ----------------------------------------------------------------
    localparam int         CTRL_W      = 8;
    localparam int         RES_W       = 12;
    localparam int         WORD_W      = 16;
    localparam int         CNT_W       = 5;
    localparam logic [4:0] SAMPLE_CNT  = 5'h01;
    localparam logic [4:0] CTRL_CNT    = 5'h07;
    localparam logic [4:0] LOAD_CNT    = 5'h03;
    localparam logic [4:0] LAST_CNT    = 5'h0F;
    localparam int         BIT_PM0     = 0;
    localparam int         BIT_PM1     = 1;
    localparam int         BIT_CHAN    = 5;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [3:0] LEAD_ZEROS  = 4'h0;
    localparam int         BUF_DEPTH   = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {PM_CS_CTRL, PM_NORMAL, PM_AUTO_SHDN, PM_AUTO_STBY} acs_pmode_t;
    typedef enum logic [1:0] {PWR_OFF, PWR_STBY, PWR_WAKE, PWR_ON} acs_pwr_t;

    // Power mode from the two mode bits of a control word
    function automatic acs_pmode_t acs_mode(input logic [CTRL_W-1:0] c);
        acs_pmode_t m;
        m = acs_pmode_t'({c[BIT_PM1], c[BIT_PM0]});
        return m;
    endfunction
endpackage

// *** src/acs_edge.sv ***
// Edge detector for the synchronous chip select and serial clock inputs
`timescale 1ns/1ps
module acs_edge
    import acs_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] sig_i,
    output logic      [1:0] rise_o,
    output logic      [1:0] fall_o
);
    logic [1:0] prev_reg;

    // ----------------------------------------------------------------
    // Per-signal history and edge pulses
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            // Reset history high: chip select idles high, the clock may too
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    prev_reg[g] <= 1'b1;
                end else begin
                    prev_reg[g] <= sig_i[g];
                end
            end
            assign rise_o[g] = sig_i[g] & ~prev_reg[g];
            assign fall_o[g] = ~sig_i[g] & prev_reg[g];
        end
    endgenerate
endmodule

// *** src/acs_fifo2.sv ***
// Two-entry result buffer with valid/ready on both sides
`timescale 1ns/1ps
module acs_fifo2
    import acs_pkg::*;
#(
    parameter int DW = 12
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire logic [DW-1:0] in_data_i,
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output logic      [DW-1:0] out_data_o
);
    logic [DW-1:0] mem_reg [BUF_DEPTH];
    logic          wr_ptr_reg;
    logic          rd_ptr_reg;
    logic [1:0]    count_reg;
    logic          push;
    logic          pop;

    // Full and empty straight from the occupancy count
    assign in_ready_o  = (count_reg != 2'h2);
    assign out_valid_o = (count_reg != 2'h0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_ready_i & out_valid_o;
    assign out_data_o  = mem_reg[rd_ptr_reg];

    // ----------------------------------------------------------------
    // Storage and pointers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
        end
    end
endmodule

// *** verification/acs_conv_ctrl_monitor.sv ***
// Port-level assertions for the serial conversion control block
`timescale 1ns/1ps
module acs_conv_ctrl_monitor
    import acs_pkg::*;
(
    input wire logic              mclk_i,
    input wire logic              rst_n_i,
    input wire logic              cs_n_i,
    input wire logic              sclk_i,
    input wire logic              dout_o,
    input wire logic              dout_oe_o,
    input wire logic              track_hold_o,
    input wire logic              conv_start_o,
    input wire logic              conv_busy_o,
    input wire logic              xfer_done_o,
    input wire logic [CTRL_W-1:0] ctrl_word_o,
    input wire logic              power_mode_high_bit_o,
    input wire logic              power_mode_low_bit_o,
    input wire logic              core_power_o,
    input wire logic              ref_power_o,
    input wire logic              power_ready_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------------------------------
    // Serial output and sampling sequence
    // ----------------------------------------------------------------
    a_oe_release: assert property (cs_n_i [*3] |-> !dout_oe_o)
        else $error("data output driven with chip select high");
    a_track_open: assert property ($fell(cs_n_i) |-> ##[1:3] !track_hold_o)
        else $error("no track after chip select fall");
    a_start_hold: assert property (conv_start_o |-> $rose(track_hold_o) && conv_busy_o ##1 !conv_start_o)
        else $error("start pulse without hold");
    a_end_release: assert property (xfer_done_o |-> !conv_busy_o && !track_hold_o ##1 !xfer_done_o)
        else $error("conversion still open at transfer end");
    a_ctrl_frame: assert property ($changed(ctrl_word_o) |-> conv_busy_o && !cs_n_i)
        else $error("control word changed outside a transfer");
    // End of transfer is left out: a new word may start there
    a_dout_quiet: assert property ((sclk_i && !cs_n_i && !xfer_done_o) [*5] |-> $stable(dout_o))
        else $error("data output moved while clock high");

    // ----------------------------------------------------------------
    // Power modes
    // ----------------------------------------------------------------
    a_stby_entry: assert property (xfer_done_o && power_mode_high_bit_o && power_mode_low_bit_o
        |-> ##[0:1] (ref_power_o && !core_power_o))
        else $error("no standby after conversion");
    a_shdn_entry: assert property (xfer_done_o && power_mode_high_bit_o && !power_mode_low_bit_o
        |-> ##[0:1] !ref_power_o)
        else $error("no shutdown after conversion");
    a_cs_off: assert property ((cs_n_i && !power_mode_high_bit_o && !power_mode_low_bit_o) [*3] |-> !ref_power_o)
        else $error("powered while chip select high");
    a_normal_on: assert property ((!power_mode_high_bit_o && power_mode_low_bit_o) [*3] |-> core_power_o)
        else $error("normal mode not powered");
    a_stby_wake: assert property (ref_power_o && !core_power_o && !cs_n_i && $fell(sclk_i)
        |-> ##[1:3] core_power_o)
        else $error("standby not left on clock fall");

    c_wrap: cover property (xfer_done_o && !cs_n_i);
    c_wake: cover property (ref_power_o && !core_power_o ##1 core_power_o);
    c_ready: cover property (conv_start_o && power_ready_o);
endmodule

// *** verification/acs_host_model.sv ***
// Serial host model: frames transfers, writes control words, reads results
`timescale 1ns/1ps
module acs_host_model
    import acs_pkg::*;
#(
    parameter int HALF = 5
) (
    input  wire logic mclk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o
);
    logic last_reg = 1'b0;
    logic line;

    // A released line shows the inverse of the last bit, never a stale copy
    always @(posedge mclk_i) begin
        if (dout_oe_i) begin
            last_reg <= dout_i;
        end
    end
    assign line = dout_oe_i ? dout_i : ~last_reg;

    // Idle high so the first edge of a frame is a falling one
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o  = 1'b0;
    end

    // One frame of n rises; acq stretches the first low phase for wake-up
    task automatic xfer(input logic [7:0] ctrl, input int n, input int acq, input bit keep,
                        output logic [15:0] word);
        word = 16'h0000;
        if (cs_n_o) begin
            @(posedge mclk_i);
            cs_n_o <= 1'b0;
            repeat (8) @(posedge mclk_i);
        end
        for (int k = 1; k <= n; k++) begin
            sclk_o <= 1'b0;
            din_o  <= (k <= 8) ? ctrl[8-k] : 1'b0;
            repeat (k == 1 ? HALF + acq : HALF) @(posedge mclk_i);
            word[16-k] = line;
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge mclk_i);
        end
        if (!keep) begin
            cs_n_o <= 1'b1;
            repeat (8) @(posedge mclk_i);
        end
    endtask
endmodule

// *** verification/acs_conv_ctrl_tb_top.sv ***
// Self-checking bench: host frames, result source and power modes
`timescale 1ns/1ps
module acs_conv_ctrl_tb_top
    import acs_pkg::*;
;
    logic              mclk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              cs_n_i, sclk_i, din_i, dout_o, dout_oe_o;
    logic              result_valid_i = 1'b0;
    logic [RES_W-1:0]  result_data_i = 12'h000;
    logic              result_ready_o, track_hold_o, conv_start_o, conv_busy_o, xfer_done_o;
    logic              chan_sel_o, power_mode_high_bit_o, power_mode_low_bit_o;
    logic              core_power_o, ref_power_o, power_ready_o, rdy;
    logic [CTRL_W-1:0] ctrl_word_o, prev, cw;
    logic [15:0]       word;
    logic [RES_W-1:0]  q[$];
    int                fail_count = 0;
    int                n_compared = 0;
    int                n_start = 0;

    always #5 mclk_i = ~mclk_i;

    acs_conv_ctrl dut (.mclk_i, .rst_n_i, .cs_n_i, .sclk_i, .din_i, .dout_o, .dout_oe_o, .result_valid_i,
        .result_data_i, .result_ready_o, .track_hold_o, .conv_start_o, .conv_busy_o, .xfer_done_o,
        .chan_sel_o, .ctrl_word_o, .power_mode_high_bit_o, .power_mode_low_bit_o, .core_power_o,
        .ref_power_o, .power_ready_o);
    acs_host_model host (.mclk_i, .dout_i(dout_o), .dout_oe_i(dout_oe_o), .cs_n_o(cs_n_i),
        .sclk_o(sclk_i), .din_o(din_i));

    // Power state at each sampling edge, and a count of sampling edges
    always @(posedge mclk_i) begin
        if (conv_start_o === 1'b1) begin
            rdy     <= power_ready_o;
            n_start <= n_start + 1;
        end
    end

    // Power outputs {ref, core} after a frame: on in normal mode or with select held in mode 00, else by mode
    function automatic logic [1:0] exp_power(input logic [7:0] c, input bit keep);
        if (c[1:0] == 2'b01 || (keep && c[1:0] == 2'b00)) begin
            return 2'b11;
        end
        return {c[1] & c[0], 1'b0};
    endfunction

    task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Core side of the buffer; a stuck ready ends the run
    task automatic push(input logic [RES_W-1:0] d);
        int t;
        t = 0;
        result_valid_i <= 1'b1;
        result_data_i  <= d;
        @(posedge mclk_i);
        while (result_ready_o !== 1'b1) begin
            t++;
            if (t > 2000) begin
                fail_count++;
                final_report();
            end
            @(posedge mclk_i);
        end
        q.push_back(d);
        result_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Full transfer with the checks that follow it; expectations from mode bits
    task automatic frame(input logic [7:0] c, input bit keep);
        logic [15:0] exp;
        int          s0;
        exp = (q.size() > 0) ? {4'h0, q.pop_front()} : 16'h0000;
        s0 = n_start;
        host.xfer(c, 16, 510, keep, word);
        chk_val("samples", 16'h0001, 16'(n_start - s0));
        chk_val("result word", exp, word);
        chk_val("control word", {8'h00, c}, {8'h00, ctrl_word_o});
        chk_bit("channel", prev[BIT_CHAN], chan_sel_o);
        chk_bit("awake at sample", 1'b1, rdy);
        chk_val("power", {14'h0, exp_power(c, keep)}, {14'h0, ref_power_o, core_power_o});
        prev = c;
    endtask

    initial begin
        void'($urandom(45));
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        chk_val("reset control", 16'h0000, {8'h00, ctrl_word_o});
        chk_val("reset power", 16'h0000, {14'h0, ref_power_o, core_power_o});
        chk_bit("reset ready", 1'b1, result_ready_o);
        prev = 8'h00;
        $display("test reset done");
        // Fill the buffer until it refuses, then drain past empty
        push(12'($urandom));
        push(12'hFFF);
        chk_bit("ready when full", 1'b0, result_ready_o);
        frame(8'h21, 1'b0);
        frame(8'h01, 1'b0);
        frame(8'h01, 1'b0);
        $display("test buffer done");
        // Every mode in turn, random words, three frames chained without a chip select edge;
        // no chain leaves an auto mode, which only wakes after a select fall
        for (int i = 0; i < 12; i++) begin
            if ($urandom_range(1) == 1) begin
                push(12'($urandom));
            end
            cw = 8'($urandom);
            frame({cw[7:2], 2'(i)}, i == 4 || i == 5);
        end
        $display("test modes done");
        // Cut short before the control word completes
        host.xfer(8'hFF, 3, 510, 1'b0, word);
        chk_val("control after abort", {8'h00, prev}, {8'h00, ctrl_word_o});
        chk_bit("busy after abort", 1'b0, conv_busy_o);
        frame(8'h01, 1'b0);
        $display("test abort done");
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        chk_val("control after reset", 16'h0000, {8'h00, ctrl_word_o});
        prev = 8'h00;
        q.delete();
        frame(8'h00, 1'b0);
        $display("test reset again done");
        final_report();
    end
endmodule

bind acs_conv_ctrl acs_conv_ctrl_monitor mon (.mclk_i, .rst_n_i, .cs_n_i, .sclk_i, .dout_o, .dout_oe_o,
    .track_hold_o, .conv_start_o, .conv_busy_o, .xfer_done_o, .ctrl_word_o, .power_mode_high_bit_o,
    .power_mode_low_bit_o, .core_power_o, .ref_power_o, .power_ready_o);
